// ### ccfg_regs.sv
/*
  AHB-Lite slave holding the channel configuration and transmit jitter registers.
  Assumes one-word transfers on a single-slave bus clocked by REF_CLK; registers sit
  at byte address four times their index; the timer tick, pending sources and FIFO
  fill come from logic on the same clock.
*/
`timescale 1ns/1ns
module ccfg_regs (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SECOND_TICK,
  input wire logic [6:0] CHAN0_IRQ_SOURCES,
  input wire logic [7:0] TX_FIFO_FILL,
  output logic CHAN_SOFT_RESET,
  output logic LINE_RATE_E1,
  output logic TX_ATTEN_BYPASS,
  output logic [7:0] TX_FIFO_DEPTH,
  output logic [15:0] TX_CORNER_CHZ,
  output logic TX_SPEED_UP,
  output logic TX_SLOW_DOWN
);
  ccfg_pkg::ccfg_state_t s;
  ccfg_pkg::ccfg_state_t next_s;
  logic lim_up;
  logic lim_down;
  logic irq_pending;
  logic tx_active;
  logic wr_jit;
  logic wr_tmr;
  logic wr_chan;

  // Any channel 0 source, including the timer flag
  assign irq_pending = (|CHAN0_IRQ_SOURCES) || s.tick_flag;
  assign tx_active = HSEL && HREADY && HTRANS[1];
  assign wr_jit = s.sel && s.write && (s.addr == ccfg_pkg::ADDR_JIT_CFG);
  assign wr_tmr = s.sel && s.write && (s.addr == ccfg_pkg::ADDR_TMR_STS);
  assign wr_chan = s.sel && s.write && (s.addr == ccfg_pkg::ADDR_CHAN_CFG);

  ccfg_limiter u_limiter (
    .clk(REF_CLK),
    .rst(RST),
    .enable(s.jcfg.limit_en && s.jcfg.atten_en),
    .depth(s.depth_bits),
    .fill(TX_FIFO_FILL),
    .speed_up(lim_up),
    .slow_down(lim_down)
  );

  always_comb begin
    next_s = s;
    next_s.ready = 1'b1;
    next_s.sel = tx_active;
    next_s.write = HWRITE;
    // Word index: the byte address is four times the register index
    next_s.addr = HADDR[13:2];
    next_s.rdata = '0;
    if (tx_active && !HWRITE) begin
      case (HADDR[13:2])
        ccfg_pkg::ADDR_JIT_CFG: next_s.rdata[7:0] = {3'h0, s.jcfg};
        ccfg_pkg::ADDR_IRQ_SRC: next_s.rdata[ccfg_pkg::BIT_IRQ_PEND] = irq_pending;
        ccfg_pkg::ADDR_TMR_STS: next_s.rdata[ccfg_pkg::BIT_TICK_FLAG] = s.tick_flag;
        ccfg_pkg::ADDR_CHAN_CFG: next_s.rdata[7:0] = {6'h00, s.chan_rst, s.rate_sel};
        ccfg_pkg::ADDR_RATE_STS: next_s.rdata[7:0] = s.depth_bits;
        default: next_s.rdata = '0;
      endcase
    end
    if (wr_jit) begin
      next_s.jcfg = ccfg_pkg::ccfg_jcfg_t'(HWDATA[4:0] & ccfg_pkg::JIT_CFG_MASK[4:0]);
    end
    // Set wins over a same-cycle clear
    if (SECOND_TICK) begin
      next_s.tick_flag = 1'b1;
    end else if (wr_tmr && HWDATA[ccfg_pkg::BIT_TICK_FLAG]) begin
      next_s.tick_flag = 1'b0;
    end
    if (wr_chan) begin
      next_s.rate_sel = HWDATA[ccfg_pkg::BIT_RATE_SEL];
    end
    if (wr_chan && HWDATA[ccfg_pkg::BIT_SOFT_RST]) begin
      next_s.rst_count = ccfg_pkg::SOFT_RST_CYCLES;
      next_s.chan_rst = 1'b1;
    end else if (s.rst_count != 4'h0) begin
      next_s.rst_count = s.rst_count - 4'h1;
      next_s.chan_rst = (s.rst_count != 4'h1);
    end
    case (s.jcfg.depth_sel)
      2'b00: next_s.depth_bits = ccfg_pkg::DEPTH_128;
      2'b01: next_s.depth_bits = ccfg_pkg::DEPTH_64;
      default: next_s.depth_bits = ccfg_pkg::DEPTH_32;
    endcase
    case ({s.jcfg.corner_sel, s.rate_sel})
      2'b00: next_s.corner_chz = ccfg_pkg::CORNER_T1_WIDE;
      2'b01: next_s.corner_chz = ccfg_pkg::CORNER_E1_WIDE;
      2'b10: next_s.corner_chz = ccfg_pkg::CORNER_T1_NARROW;
      default: next_s.corner_chz = ccfg_pkg::CORNER_E1_NARROW;
    endcase
    next_s.bypass = !s.jcfg.atten_en;
    next_s.speed_up = lim_up;
    next_s.slow_down = lim_down;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s <= '0;
      s.ready <= 1'b1;
      s.bypass <= 1'b1;
      s.depth_bits <= ccfg_pkg::DEPTH_128;
      s.corner_chz <= ccfg_pkg::CORNER_T1_WIDE;
    end else begin
      s <= next_s;
    end
  end

  assign HRDATA = s.rdata;
  assign HREADYOUT = s.ready;
  assign HRESP = 1'b0;
  assign CHAN_SOFT_RESET = s.chan_rst;
  assign LINE_RATE_E1 = s.rate_sel;
  assign TX_ATTEN_BYPASS = s.bypass;
  assign TX_FIFO_DEPTH = s.depth_bits;
  assign TX_CORNER_CHZ = s.corner_chz;
  assign TX_SPEED_UP = s.speed_up;
  assign TX_SLOW_DOWN = s.slow_down;

  chk_pending_read: assert property (@(posedge REF_CLK) disable iff (RST)
    tx_active && !HWRITE && HADDR[13:2] == ccfg_pkg::ADDR_IRQ_SRC |=>
      HRDATA[ccfg_pkg::BIT_IRQ_PEND] == $past(irq_pending))
    else $error("pending bit read wrong");
  chk_pending_none: assert property (@(posedge REF_CLK) disable iff (RST)
    tx_active && !HWRITE && HADDR[13:2] == ccfg_pkg::ADDR_IRQ_SRC && !irq_pending |=> HRDATA == 32'h0)
    else $error("pending word not zero");
  chk_tick_set: assert property (@(posedge REF_CLK) disable iff (RST)
    SECOND_TICK |=> s.tick_flag)
    else $error("tick flag not set");
  chk_tick_clear: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_tmr && HWDATA[ccfg_pkg::BIT_TICK_FLAG] && !SECOND_TICK |=> !s.tick_flag)
    else $error("tick flag not cleared");
  chk_tick_hold: assert property (@(posedge REF_CLK) disable iff (RST)
    !SECOND_TICK && !(wr_tmr && HWDATA[ccfg_pkg::BIT_TICK_FLAG]) |=> s.tick_flag == $past(s.tick_flag))
    else $error("tick flag changed alone");
  // Pulse spans eight cycles from the write that starts it
  chk_soft_rst: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_chan && HWDATA[ccfg_pkg::BIT_SOFT_RST] && s.rst_count == 4'h0 |=>
      CHAN_SOFT_RESET [*8] ##1 !CHAN_SOFT_RESET)
    else $error("soft reset not self clearing");
  chk_soft_idle: assert property (@(posedge REF_CLK) disable iff (RST)
    s.rst_count == 4'h0 && !(wr_chan && HWDATA[ccfg_pkg::BIT_SOFT_RST]) |=> !CHAN_SOFT_RESET)
    else $error("soft reset without write");
  chk_rate_write: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_chan |=> LINE_RATE_E1 == $past(HWDATA[ccfg_pkg::BIT_RATE_SEL]))
    else $error("rate select not written");
  chk_rate_hold: assert property (@(posedge REF_CLK) disable iff (RST)
    !wr_chan |=> $stable(LINE_RATE_E1))
    else $error("rate select changed alone");
  chk_limit_gate: assert property (@(posedge REF_CLK) disable iff (RST)
    !(s.jcfg.limit_en && s.jcfg.atten_en) |=> ##1 !TX_SPEED_UP && !TX_SLOW_DOWN)
    else $error("speed request while limit off");
  chk_bypass: assert property (@(posedge REF_CLK) disable iff (RST)
    !s.jcfg.atten_en |=> TX_ATTEN_BYPASS)
    else $error("attenuator not bypassed");
  chk_bypass_off: assert property (@(posedge REF_CLK) disable iff (RST)
    s.jcfg.atten_en |=> !TX_ATTEN_BYPASS)
    else $error("attenuator not inserted");
  chk_depth_full: assert property (@(posedge REF_CLK) disable iff (RST)
    s.jcfg.depth_sel == 2'b00 |=> TX_FIFO_DEPTH == ccfg_pkg::DEPTH_128)
    else $error("depth 128 wrong");
  chk_depth_half: assert property (@(posedge REF_CLK) disable iff (RST)
    s.jcfg.depth_sel == 2'b01 |=> TX_FIFO_DEPTH == ccfg_pkg::DEPTH_64)
    else $error("depth 64 wrong");
  chk_depth_map: assert property (@(posedge REF_CLK) disable iff (RST)
    s.jcfg.depth_sel[1] |=> TX_FIFO_DEPTH == ccfg_pkg::DEPTH_32)
    else $error("depth mapping wrong");
  chk_corner_map: assert property (@(posedge REF_CLK) disable iff (RST)
    !s.jcfg.corner_sel && !s.rate_sel |=> TX_CORNER_CHZ == ccfg_pkg::CORNER_T1_WIDE)
    else $error("corner frequency wrong");
  chk_corner_narrow: assert property (@(posedge REF_CLK) disable iff (RST)
    s.jcfg.corner_sel && s.rate_sel |=> TX_CORNER_CHZ == ccfg_pkg::CORNER_E1_NARROW)
    else $error("narrow corner wrong");
endmodule

// ### ccfg_pkg.sv
/*
  Package for the channel configuration and transmit jitter register bank:
  register offsets, field positions, reset values, bus codes and state carriers.
  Assumes a 32-bit AHB-Lite bus; the ADDR_ constants are word indexes and the
  byte address of each register is four times its index.
*/
package ccfg_pkg;
  localparam logic [11:0] ADDR_JIT_CFG = 12'h002;
  localparam logic [11:0] ADDR_IRQ_SRC = 12'h380;
  localparam logic [11:0] ADDR_TMR_STS = 12'h3c0;
  localparam logic [11:0] ADDR_CHAN_CFG = 12'h001;
  localparam logic [11:0] ADDR_RATE_STS = 12'h004;

  localparam int BIT_IRQ_PEND = 7;
  localparam int BIT_TICK_FLAG = 0;
  localparam int BIT_SOFT_RST = 1;
  localparam int BIT_RATE_SEL = 0;
  localparam int BIT_LIMIT_EN = 4;
  localparam int BIT_ATTEN_EN = 3;
  localparam int BIT_DEPTH_HI = 2;
  localparam int BIT_DEPTH_LO = 1;
  localparam int BIT_CORNER = 0;

  localparam logic [7:0] RST_JIT_CFG = 8'h00;
  localparam logic [7:0] RST_CHAN_CFG = 8'h00;
  localparam logic [7:0] JIT_CFG_MASK = 8'h1f;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  localparam logic [7:0] DEPTH_128 = 8'h80;
  localparam logic [7:0] DEPTH_64 = 8'h40;
  localparam logic [7:0] DEPTH_32 = 8'h20;
  localparam logic [7:0] LIMIT_MARGIN = 8'h02;

  // Corner frequency in centihertz
  localparam logic [15:0] CORNER_T1_WIDE = 16'd500;
  localparam logic [15:0] CORNER_E1_WIDE = 16'd677;
  localparam logic [15:0] CORNER_T1_NARROW = 16'd126;
  localparam logic [15:0] CORNER_E1_NARROW = 16'd87;

  localparam logic [3:0] SOFT_RST_CYCLES = 4'h8;

  typedef struct packed {
    logic [7:0] fill;
    logic [7:0] depth;
    logic speed_up;
    logic slow_down;
  } ccfg_jit_t;

  typedef struct packed {
    logic limit_en;
    logic atten_en;
    logic [1:0] depth_sel;
    logic corner_sel;
  } ccfg_jcfg_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [11:0] addr;
    logic [31:0] rdata;
    logic ready;
    ccfg_jcfg_t jcfg;
    logic rate_sel;
    logic tick_flag;
    logic [3:0] rst_count;
    logic chan_rst;
    logic [7:0] depth_bits;
    logic [15:0] corner_chz;
    logic bypass;
    logic speed_up;
    logic slow_down;
  } ccfg_state_t;

  typedef struct packed {
    logic [7:0] fill;
    logic speed_up;
    logic slow_down;
  } ccfg_lim_state_t;
endpackage

// ### ccfg_limiter.sv
/*
  Fill-level watcher for the transmit jitter FIFO: raises a speed request near
  empty or near full while the limit function is on. Inputs come from the same clock.
*/
`timescale 1ns/1ns
module ccfg_limiter (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [7:0] depth,
  input wire logic [7:0] fill,
  output logic speed_up,
  output logic slow_down
);
  ccfg_pkg::ccfg_lim_state_t s;
  ccfg_pkg::ccfg_lim_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.fill = fill;
    // Nine bits so a fill near 255 cannot wrap past the depth
    next_s.speed_up = enable && (({1'b0, fill} + {1'b0, ccfg_pkg::LIMIT_MARGIN}) >= {1'b0, depth});
    next_s.slow_down = enable && (fill <= ccfg_pkg::LIMIT_MARGIN);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign speed_up = s.speed_up;
  assign slow_down = s.slow_down;

  chk_limit_off: assert property (@(posedge clk) disable iff (rst)
    !$past(enable) |-> !speed_up && !slow_down)
    else $error("limit request while disabled");
  chk_near_empty: assert property (@(posedge clk) disable iff (rst)
    enable && fill <= ccfg_pkg::LIMIT_MARGIN |=> slow_down)
    else $error("no slow down near empty");
endmodule

// ### testbench.sv
/*
  Self-checking bench for the channel configuration and transmit jitter registers.
  Assumes the AHB-Lite slave answers with zero wait states and is the only slave.
*/
`timescale 1ns/1ns
module testbench;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = ccfg_pkg::HSIZE_WORD;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, SECOND_TICK = 1'b0;
  logic [6:0] CHAN0_IRQ_SOURCES = 7'h0;
  logic [7:0] TX_FIFO_FILL = 8'h0;
  logic CHAN_SOFT_RESET, LINE_RATE_E1, TX_ATTEN_BYPASS, TX_SPEED_UP, TX_SLOW_DOWN;
  logic [7:0] TX_FIFO_DEPTH;
  logic [15:0] TX_CORNER_CHZ;
  logic [31:0] rd;
  int error_cnt = 0;
  int tests_run = 0;
  logic [7:0] dexp [4] = '{ccfg_pkg::DEPTH_128, ccfg_pkg::DEPTH_64, ccfg_pkg::DEPTH_32, ccfg_pkg::DEPTH_32};
  logic [15:0] cexp [4] = '{ccfg_pkg::CORNER_T1_WIDE, ccfg_pkg::CORNER_T1_NARROW,
    ccfg_pkg::CORNER_E1_WIDE, ccfg_pkg::CORNER_E1_NARROW};
  logic [7:0] lim [4][3] = '{'{8'h1e, 8'h2, 8'h0}, '{8'h1d, 8'h0, 8'h0}, '{8'h02, 8'h1, 8'h0}, '{8'h03, 8'h0, 8'h0}};

  always #5 REF_CLK = ~REF_CLK;

  ccfg_regs u_ccfg_regs (.REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SECOND_TICK(SECOND_TICK), .CHAN0_IRQ_SOURCES(CHAN0_IRQ_SOURCES),
    .TX_FIFO_FILL(TX_FIFO_FILL), .CHAN_SOFT_RESET(CHAN_SOFT_RESET), .LINE_RATE_E1(LINE_RATE_E1),
    .TX_ATTEN_BYPASS(TX_ATTEN_BYPASS), .TX_FIFO_DEPTH(TX_FIFO_DEPTH), .TX_CORNER_CHZ(TX_CORNER_CHZ),
    .TX_SPEED_UP(TX_SPEED_UP), .TX_SLOW_DOWN(TX_SLOW_DOWN));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  // Ready and read data are taken from the settled value ahead of the sampling edge
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    logic rdy;
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= ccfg_pkg::HTRANS_NONSEQ;
    HADDR <= {18'h0, a, 2'b00};
    HWRITE <= wr;
    do begin
      @(negedge REF_CLK);
      rdy = HREADYOUT;
      @(posedge REF_CLK);
    end while (rdy !== 1'b1);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= wd;
    do begin
      @(negedge REF_CLK);
      rdy = HREADYOUT;
      rdat = HRDATA;
      @(posedge REF_CLK);
    end while (rdy !== 1'b1);
    chk({31'h0, HRESP}, 32'h0, "response");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] junk;
    ahb(1'b1, a, d, junk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk(v, exp, msg);
  endtask

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #300000;
    error_cnt++;
    complete_run();
  end

  initial begin
    logic [7:0] v;
    repeat (10) @(posedge REF_CLK);
    RST <= 1'b0;
    @(negedge REF_CLK);
    chk({TX_ATTEN_BYPASS, TX_FIFO_DEPTH, TX_CORNER_CHZ}, {7'h0, 1'b1, ccfg_pkg::DEPTH_128, ccfg_pkg::CORNER_T1_WIDE}, "reset outs");
    rchk(ccfg_pkg::ADDR_JIT_CFG, 32'h0, "jit reset");
    rchk(ccfg_pkg::ADDR_CHAN_CFG, 32'h0, "chan reset");
    rchk(ccfg_pkg::ADDR_IRQ_SRC, 32'h0, "src reset");
    rchk(ccfg_pkg::ADDR_TMR_STS, 32'h0, "tick reset");
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      v = {3'h0, 1'b0, i[1] ^ i[0] ^ i[2], i[2:1], i[0]};
      wr(ccfg_pkg::ADDR_CHAN_CFG, {31'h0, i[3]});
      wr(ccfg_pkg::ADDR_JIT_CFG, 32'hffffffe0 | v);
      rchk(ccfg_pkg::ADDR_JIT_CFG, {24'h0, v}, "jit readback");
      rchk(ccfg_pkg::ADDR_RATE_STS, {24'h0, dexp[i[2:1]]}, "depth status");
      chk({31'h0, LINE_RATE_E1}, {31'h0, i[3]}, "rate");
      chk({31'h0, TX_ATTEN_BYPASS}, {31'h0, ~v[3]}, "bypass");
      chk({24'h0, TX_FIFO_DEPTH}, {24'h0, dexp[i[2:1]]}, "depth");
      chk({16'h0, TX_CORNER_CHZ}, {16'h0, cexp[{i[3], i[0]}]}, "corner");
    end
    $display("test fields done");
    wr(ccfg_pkg::ADDR_CHAN_CFG, 32'h3);
    @(negedge REF_CLK);
    chk({31'h0, CHAN_SOFT_RESET}, 32'h1, "soft reset on");
    rchk(ccfg_pkg::ADDR_CHAN_CFG, 32'h3, "soft reset read");
    repeat (12) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk({31'h0, CHAN_SOFT_RESET}, 32'h0, "soft reset off");
    rchk(ccfg_pkg::ADDR_CHAN_CFG, 32'h1, "soft reset cleared");
    $display("test soft reset done");
    @(posedge REF_CLK);
    SECOND_TICK <= 1'b1;
    @(posedge REF_CLK);
    SECOND_TICK <= 1'b0;
    rchk(ccfg_pkg::ADDR_TMR_STS, 32'h1, "tick set");
    rchk(ccfg_pkg::ADDR_IRQ_SRC, 32'h80, "pend tick");
    wr(ccfg_pkg::ADDR_TMR_STS, 32'h0);
    rchk(ccfg_pkg::ADDR_TMR_STS, 32'h1, "tick kept");
    wr(ccfg_pkg::ADDR_TMR_STS, 32'h1);
    rchk(ccfg_pkg::ADDR_TMR_STS, 32'h0, "tick clear");
    rchk(ccfg_pkg::ADDR_IRQ_SRC, 32'h0, "pend none");
    CHAN0_IRQ_SOURCES <= 7'h40;
    rchk(ccfg_pkg::ADDR_IRQ_SRC, 32'h80, "pend src");
    CHAN0_IRQ_SOURCES <= 7'h0;
    rchk(ccfg_pkg::ADDR_IRQ_SRC, 32'h0, "pend gone");
    // Tick lands on the same edge as the clearing write
    fork
      wr(ccfg_pkg::ADDR_TMR_STS, 32'h1);
      begin
        repeat (2) @(posedge REF_CLK);
        SECOND_TICK <= 1'b1;
        @(posedge REF_CLK);
        SECOND_TICK <= 1'b0;
      end
    join
    rchk(ccfg_pkg::ADDR_TMR_STS, 32'h1, "tick set wins");
    wr(ccfg_pkg::ADDR_TMR_STS, 32'h1);
    rchk(ccfg_pkg::ADDR_TMR_STS, 32'h0, "tick clear again");
    $display("test irq done");
    wr(ccfg_pkg::ADDR_JIT_CFG, 32'h1c);
    for (int i = 0; i < 4; i++) begin
      TX_FIFO_FILL <= lim[i][0];
      repeat (3) @(posedge REF_CLK);
      @(negedge REF_CLK);
      chk({30'h0, TX_SPEED_UP, TX_SLOW_DOWN}, {24'h0, lim[i][1] | lim[i][2]}, "limit");
    end
    TX_FIFO_FILL <= 8'h1e;
    wr(ccfg_pkg::ADDR_JIT_CFG, 32'h0c);
    repeat (3) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk({30'h0, TX_SPEED_UP, TX_SLOW_DOWN}, 32'h0, "limit off");
    wr(ccfg_pkg::ADDR_JIT_CFG, 32'h14);
    repeat (3) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk({30'h0, TX_SPEED_UP, TX_SLOW_DOWN}, 32'h0, "atten off");
    $display("test limit done");
    wr(12'h100, 32'hff);
    rchk(12'h100, 32'h0, "unmapped");
    rchk(ccfg_pkg::ADDR_JIT_CFG, 32'h14, "unmapped no effect");
    $display("test unmapped done");
    @(posedge REF_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    @(negedge REF_CLK);
    chk({31'h0, LINE_RATE_E1}, 32'h0, "rate after reset");
    chk({24'h0, TX_FIFO_DEPTH}, {24'h0, ccfg_pkg::DEPTH_128}, "depth after reset");
    rchk(ccfg_pkg::ADDR_JIT_CFG, 32'h0, "jit after reset");
    rchk(ccfg_pkg::ADDR_CHAN_CFG, 32'h0, "chan after reset");
    $display("test mid reset done");
    complete_run();
  end
endmodule
